// ### lfps_exit_pkg.sv
// How it works
// - Base-rate start needs sixteen consecutive valid bursts sent before equalization.
// - Handshake done: two bursts received, four sent (one at enhanced rate) after first received burst.
// - Enhanced rate: two first-signature bursts sent after a signature received, enter confirmation.
// - Fallback needs no signature seen, four first-signature sent, and handshake done.
// - After fallback, go base rate; equalize on silence expiry or sixteen more bursts.
// - Enhanced port runs a 60 us silence timer after the handshake completes.
// - Upstream enters compliance on 360 ms expiry if never trained and no exit.
// - Downstream enters compliance on expiry only when enabled and untrained since enabling.
// - Downstream on expiry: receiver detect when count below two, inactive at two.
// - Trained upstream on expiry: hub to receiver detect, peripheral to disabled.
// - Directed disable or warm reset on a downstream port, detected warm reset on an upstream port, leave either substate at once.
// - Confirmation sends second signatures; after 64 received without one, fixed bursts.
// - Handshake timer keeps running without restart when confirmation is entered.
// - Two second-signature bursts sent after one received, go to port matching.
// - Confirmation falls back on silence expiry or twenty fixed bursts after no signature.
// - Confirmation expiry: hub upstream to receiver detect, peripheral to disabled.
// - Confirmation expiry on downstream: receiver detect below two, inactive at two.
// - Switch to base rate one cycle after the partner is found base rate.
// - Timeout count saturates at two; cleared on resets, removal and final exits.
// - Handshake timer starts on entry to the handshake substate.
package lfps_exit_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam int CTRL_DOWNSTREAM = 0;
  localparam int CTRL_HUB = 1;
  localparam int CTRL_ENHANCED = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int CMD_START = 0;
  localparam int CMD_DISABLE = 1;
  localparam int CMD_WARM_RESET = 2;
  localparam int CMD_TERM_REMOVED = 3;
  localparam int CMD_COMPLIANCE_EN = 4;
  localparam int CMD_LINK_ACTIVE = 5;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] MIN_SENT = 7'h10;
  localparam logic [CNT_W-1:0] HS_RX = 7'h02;
  localparam logic [CNT_W-1:0] HS_TX_BASE = 7'h04;
  localparam logic [CNT_W-1:0] HS_TX_SIG = 7'h01;
  localparam logic [CNT_W-1:0] SIG_TX = 7'h02;
  localparam logic [CNT_W-1:0] NOSIG_RX = 7'h10;
  localparam logic [CNT_W-1:0] FB_SIG_TX = 7'h04;
  localparam logic [CNT_W-1:0] FB_EXTRA = 7'h10;
  localparam logic [CNT_W-1:0] PLUS_NOSIG_RX = 7'h40;
  localparam logic [CNT_W-1:0] PLUS_EXTRA = 7'h14;
  localparam logic [CNT_W-1:0] CNT_MAX = 7'h40;
  localparam logic [1:0] TIMEOUT_MAX = 2'h2;
  localparam longint unsigned CLK_HZ = 64'd10_000_000;
  localparam longint unsigned SILENCE_US = 64'd60;
  localparam longint unsigned HANDSHAKE_MS = 64'd360;
  localparam int unsigned SILENCE_CYC = 32'((SILENCE_US * CLK_HZ + 64'd999_999) / 64'd1_000_000);
  localparam int unsigned HANDSHAKE_CYC = 32'((HANDSHAKE_MS * CLK_HZ) / 64'd1_000);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LFPS = 2'b01,
    ST_PLUS = 2'b10,
    ST_DONE = 2'b11
  } state_e;
  typedef enum logic [2:0] {
    EX_NONE = 3'b000,
    EX_RXEQ = 3'b001,
    EX_PORTMATCH = 3'b010,
    EX_COMPLIANCE = 3'b011,
    EX_RXDETECT = 3'b100,
    EX_INACTIVE = 3'b101,
    EX_DISABLED = 3'b110
  } exit_e;
  typedef enum logic [1:0] {
    TX_NONE = 2'b00,
    TX_POLL = 2'b01,
    TX_SIG1 = 2'b10,
    TX_SIG2 = 2'b11
  } tx_kind_e;
  localparam logic [1:0] RX_PLAIN = 2'h0;
  localparam logic [1:0] RX_SIG1 = 2'h1;
  localparam logic [1:0] RX_SIG2 = 2'h2;
endpackage : lfps_exit_pkg

// ### burst_counter.sv
`timescale 1ns/10ps
module burst_counter #(
  parameter int W = 7,
  parameter logic [W-1:0] MAX = '1
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic clr, // Clear, wins over inc
  input wire logic inc, // Count one event
  output logic [W-1:0] cnt // Saturating count
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else if (inc && cnt != MAX) begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule : burst_counter

// ### cycle_timer.sv
`timescale 1ns/10ps
module cycle_timer #(
  parameter int W = 22,
  parameter int unsigned TERM = 600
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic restart, // Hold at zero
  input wire logic run, // Count enable
  output logic expired // Level until restart
);
  localparam logic [W-1:0] TERM_W = W'(TERM - 1);
  logic [W-1:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      expired <= 1'b0;
    end else if (restart) begin
      cnt_ff <= '0;
      expired <= 1'b0;
    end else if (run && !expired) begin
      cnt_ff <= cnt_ff + 1'b1;
      expired <= (cnt_ff == TERM_W);
    end
  end
endmodule : cycle_timer

// ### polling_lfps_exit_control.sv
`timescale 1ns/10ps
module polling_lfps_exit_control
  import lfps_exit_pkg::*;
#(
  parameter int unsigned HS_CYCLES = lfps_exit_pkg::HANDSHAKE_CYC,
  parameter int unsigned SIL_CYCLES = lfps_exit_pkg::SILENCE_CYC
) (
  input wire logic pclk, // 10 MHz clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped
  input wire logic burst_sent, // Pulse: one burst transmitted
  input wire logic burst_rcvd, // Pulse: one valid burst received
  input wire logic [1:0] rcvd_sig, // Signature of received burst
  input wire logic lfps_present, // Level: signalling seen on line
  input wire logic warm_reset_seen, // Pulse: warm reset detected
  output lfps_exit_pkg::tx_kind_e tx_kind, // Burst kind to transmit
  output logic base_rate, // Operating at base rate
  output logic exit_valid, // Pulse: exit decided
  output lfps_exit_pkg::exit_e exit_target // Chosen next state
);
  import lfps_exit_pkg::*;

  state_e st_ff;
  logic [2:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic exit_valid_ff;
  exit_e exit_ff;
  logic base_ff, fb_ff, fixed_ff, sig_ff, hs_ff;
  logic trained_ff, done_en_ff, comp_en_ff;
  logic [1:0] tocnt_ff;
  logic [CNT_W-1:0] sent_cnt, rx_cnt, after_cnt, sig_cnt, extra_cnt;
  logic hs_exp, sil_exp;
  logic active, cnt_clr, go_plus, hs_now, fb_now, extra_clr;
  logic wr_cmd, ctl_wr, mapped;
  logic cmd_start, cmd_disable, cmd_warm, cmd_term, cmd_comp, cmd_active;
  logic downstream, hub, enhanced;
  exit_e nxt_exit;
  logic nxt_timeout;

  assign downstream = ctrl_ff[CTRL_DOWNSTREAM];
  assign hub = ctrl_ff[CTRL_HUB];
  assign enhanced = ctrl_ff[CTRL_ENHANCED];

  // APB slave: zero wait states, read data captured in the setup phase
  assign pready = 1'b1;
  assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_CMD) || (paddr == OFS_STAT);
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_ff;
  assign ctl_wr = psel && penable && pwrite && (paddr == OFS_CTRL);
  assign wr_cmd = psel && penable && pwrite && (paddr == OFS_CMD);
  assign cmd_start = wr_cmd && pwdata[CMD_START];
  assign cmd_disable = wr_cmd && pwdata[CMD_DISABLE];
  assign cmd_warm = wr_cmd && pwdata[CMD_WARM_RESET];
  assign cmd_term = wr_cmd && pwdata[CMD_TERM_REMOVED];
  assign cmd_comp = wr_cmd && pwdata[CMD_COMPLIANCE_EN];
  assign cmd_active = wr_cmd && pwdata[CMD_LINK_ACTIVE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (ctl_wr) begin
      ctrl_ff <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_CTRL: prdata_ff <= {29'h0, ctrl_ff};
        OFS_STAT: prdata_ff <= {16'h0, 2'h0, tocnt_ff, 1'b0, comp_en_ff, trained_ff,
                                base_ff, 1'b0, exit_ff, 2'h0, st_ff};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign active = (st_ff == ST_LFPS) || (st_ff == ST_PLUS);
  assign cnt_clr = !active || go_plus;

  // Event counters; each clears on entry to a substate
  burst_counter #(.W(CNT_W), .MAX(CNT_MAX)) u_sent (
    .pclk(pclk), .presetn(presetn), .clr(cnt_clr), .inc(burst_sent), .cnt(sent_cnt));
  burst_counter #(.W(CNT_W), .MAX(CNT_MAX)) u_rx (
    .pclk(pclk), .presetn(presetn), .clr(cnt_clr), .inc(burst_rcvd), .cnt(rx_cnt));
  burst_counter #(.W(CNT_W), .MAX(CNT_MAX)) u_after (
    .pclk(pclk), .presetn(presetn), .clr(cnt_clr),
    .inc(burst_sent && rx_cnt != '0), .cnt(after_cnt));
  burst_counter #(.W(CNT_W), .MAX(CNT_MAX)) u_sig (
    .pclk(pclk), .presetn(presetn), .clr(cnt_clr),
    .inc(burst_sent && sig_ff && (tx_kind == TX_SIG1 || tx_kind == TX_SIG2)), .cnt(sig_cnt));
  assign extra_clr = cnt_clr || ((st_ff == ST_LFPS) ? !fb_ff : !fixed_ff);
  burst_counter #(.W(CNT_W), .MAX(CNT_MAX)) u_extra (
    .pclk(pclk), .presetn(presetn), .clr(extra_clr), .inc(burst_sent), .cnt(extra_cnt));

  // Handshake timer restarts only outside the substates, so it spans both
  cycle_timer #(.W(32), .TERM(HS_CYCLES)) u_hs_timer (
    .pclk(pclk), .presetn(presetn), .restart(!active), .run(active), .expired(hs_exp));
  // Silence timer: held at zero while signalling is present or before the handshake
  cycle_timer #(.W(16), .TERM(SIL_CYCLES)) u_sil_timer (
    .pclk(pclk), .presetn(presetn), .restart(!active || !hs_ff || lfps_present),
    .run(enhanced), .expired(sil_exp));

  // Handshake: enhanced side counts one first signature sent in place of four
  assign hs_now = (st_ff == ST_LFPS) && (rx_cnt >= HS_RX) &&
                  (after_cnt >= (base_ff ? HS_TX_BASE : HS_TX_SIG));
  assign fb_now = (st_ff == ST_LFPS) && !base_ff && !sig_ff && (rx_cnt >= NOSIG_RX) &&
                  (sent_cnt >= FB_SIG_TX) && hs_now;
  assign go_plus = (st_ff == ST_LFPS) && !base_ff && sig_ff && (sig_cnt >= SIG_TX) &&
                   !cmd_disable && !cmd_warm && !warm_reset_seen;

  // Exit decision; directed exits first, then training exits, then timeouts
  always_comb begin
    nxt_exit = EX_NONE;
    nxt_timeout = 1'b0;
    if (active) begin
      if (downstream && cmd_disable) begin
        nxt_exit = EX_DISABLED;
      end else if ((downstream && cmd_warm) || (!downstream && warm_reset_seen)) begin
        nxt_exit = EX_RXDETECT;
      end else if (st_ff == ST_LFPS && !enhanced && sent_cnt >= MIN_SENT && hs_now) begin
        nxt_exit = EX_RXEQ;
      end else if (st_ff == ST_LFPS && fb_ff && (sil_exp || extra_cnt >= FB_EXTRA)) begin
        nxt_exit = EX_RXEQ;
      end else if (st_ff == ST_PLUS && sig_ff && sig_cnt >= SIG_TX) begin
        nxt_exit = EX_PORTMATCH;
      end else if (st_ff == ST_PLUS && (sil_exp || (fixed_ff && extra_cnt >= PLUS_EXTRA))) begin
        nxt_exit = EX_RXEQ;
      end else if (hs_exp && !go_plus) begin
        if (st_ff == ST_LFPS && !downstream && !trained_ff) begin
          nxt_exit = EX_COMPLIANCE;
        end else if (st_ff == ST_LFPS && downstream && comp_en_ff && !done_en_ff) begin
          nxt_exit = EX_COMPLIANCE;
        end else if (!downstream) begin
          nxt_exit = hub ? EX_RXDETECT : EX_DISABLED;
        end else if (tocnt_ff == TIMEOUT_MAX) begin
          nxt_exit = EX_INACTIVE;
        end else begin
          nxt_exit = EX_RXDETECT;
          nxt_timeout = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
    end else if (active && nxt_exit != EX_NONE) begin
      st_ff <= ST_DONE;
    end else if (go_plus) begin
      st_ff <= ST_PLUS;
    end else if (!active && cmd_start) begin
      st_ff <= ST_LFPS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_ff <= EX_NONE;
      exit_valid_ff <= 1'b0;
    end else begin
      exit_valid_ff <= active && (nxt_exit != EX_NONE);
      if (active && nxt_exit != EX_NONE) begin
        exit_ff <= nxt_exit;
      end else if (!active && cmd_start) begin
        exit_ff <= EX_NONE;
      end
    end
  end

  // Rate drops to base on the clock edge after fallback is found
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_ff <= 1'b1;
      fb_ff <= 1'b0;
    end else if (!active && cmd_start) begin
      base_ff <= !enhanced;
      fb_ff <= 1'b0;
    end else if (fb_now) begin
      base_ff <= 1'b1;
      fb_ff <= 1'b1;
    end else if (active && (nxt_exit == EX_RXEQ)) begin
      base_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_ff <= 1'b0;
      hs_ff <= 1'b0;
    end else begin
      if (!active) begin
        sig_ff <= 1'b0;
      end else if (go_plus) begin
        // A second signature landing on the entry edge must not be lost
        sig_ff <= burst_rcvd && (rcvd_sig == RX_SIG2);
      end else if (burst_rcvd && ((st_ff == ST_LFPS && rcvd_sig != RX_PLAIN) ||
                                  (st_ff == ST_PLUS && rcvd_sig == RX_SIG2))) begin
        sig_ff <= 1'b1;
      end
      if (!active) begin
        hs_ff <= 1'b0;
      end else if (hs_now) begin
        hs_ff <= 1'b1;
      end
    end
  end

  // Fixed-period bursts after a long run of receptions with no second signature
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_ff <= 1'b0;
    end else if (st_ff != ST_PLUS) begin
      fixed_ff <= 1'b0;
    end else if (!sig_ff && rx_cnt >= PLUS_NOSIG_RX) begin
      fixed_ff <= 1'b1;
    end
  end

  // Compliance path state; a handshake completion beats a re-enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trained_ff <= 1'b0;
      done_en_ff <= 1'b0;
      comp_en_ff <= 1'b0;
    end else begin
      if (hs_now) begin
        trained_ff <= 1'b1;
      end
      if (hs_now) begin
        done_en_ff <= 1'b1;
      end else if (cmd_comp) begin
        done_en_ff <= 1'b0;
      end
      if (cmd_warm || warm_reset_seen || (active && nxt_exit == EX_COMPLIANCE)) begin
        comp_en_ff <= 1'b0;
      end else if (cmd_comp) begin
        comp_en_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tocnt_ff <= 2'h0;
    end else if (cmd_warm || warm_reset_seen || cmd_term || cmd_active ||
                 (active && (nxt_exit == EX_DISABLED || nxt_exit == EX_INACTIVE))) begin
      tocnt_ff <= 2'h0;
    end else if (active && nxt_timeout && tocnt_ff != TIMEOUT_MAX) begin
      tocnt_ff <= tocnt_ff + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_kind <= TX_NONE;
    end else begin
      case (st_ff)
        ST_LFPS: tx_kind <= (base_ff || fb_now) ? TX_POLL : TX_SIG1;
        ST_PLUS: tx_kind <= (fixed_ff || (!sig_ff && rx_cnt >= PLUS_NOSIG_RX)) ?
                            TX_POLL : TX_SIG2;
        default: tx_kind <= TX_NONE;
      endcase
    end
  end

  assign base_rate = base_ff;
  assign exit_valid = exit_valid_ff;
  assign exit_target = exit_ff;

  chk_base_exit_needs16: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff == ST_LFPS && !enhanced && nxt_exit == EX_RXEQ) |-> sent_cnt >= MIN_SENT)
    else $error("base exit before sixteen bursts sent");
  chk_hs_needs_rx: assert property (@(posedge pclk) disable iff (!presetn)
    hs_now |-> (rx_cnt >= HS_RX && after_cnt != '0))
    else $error("handshake done without receptions");
  chk_plus_entry: assert property (@(posedge pclk) disable iff (!presetn)
    go_plus |=> st_ff == ST_PLUS || st_ff == ST_DONE)
    else $error("confirmation substate not entered");
  chk_fallback_rate: assert property (@(posedge pclk) disable iff (!presetn)
    fb_now |=> base_rate && fb_ff)
    else $error("rate not switched on fallback");
  chk_hs_no_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff == ST_LFPS && go_plus) |=> u_hs_timer.cnt_ff != '0)
    else $error("handshake timer restarted on entry");
  chk_exit_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (active && nxt_exit != EX_NONE) |=> exit_valid && st_ff == ST_DONE ##1 !exit_valid)
    else $error("exit not flagged for one cycle");
  chk_tocnt_sat: assert property (@(posedge pclk) disable iff (!presetn)
    tocnt_ff <= TIMEOUT_MAX)
    else $error("timeout count beyond two");
  chk_inactive_at2: assert property (@(posedge pclk) disable iff (!presetn)
    (exit_valid && exit_target == EX_INACTIVE) |-> $past(tocnt_ff) == TIMEOUT_MAX)
    else $error("inactive without saturated count");
  chk_fixed_tx: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff == ST_PLUS && fixed_ff) [*2] |-> tx_kind == TX_POLL)
    else $error("fixed bursts not sent");
  chk_upstream_comp: assert property (@(posedge pclk) disable iff (!presetn)
    (exit_valid && exit_target == EX_COMPLIANCE) |-> $past(downstream) ? $past(comp_en_ff)
                                                    : !$past(trained_ff))
    else $error("compliance entered without its conditions");
  chk_hs_start: assert property (@(posedge pclk) disable iff (!presetn)
    (!active && cmd_start) |=> st_ff == ST_LFPS && !hs_exp)
    else $error("handshake timer not fresh on entry");
  chk_disable_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (active && downstream && cmd_disable) |=> exit_valid && exit_target == EX_DISABLED)
    else $error("directed disable not taken");
  chk_warm_up: assert property (@(posedge pclk) disable iff (!presetn)
    (active && !downstream && warm_reset_seen) |=> exit_valid && exit_target == EX_RXDETECT)
    else $error("detected warm reset not taken");
  chk_rxeq_base: assert property (@(posedge pclk) disable iff (!presetn)
    (exit_valid && exit_target == EX_RXEQ) |-> base_rate)
    else $error("equalization exit not at base rate");
  chk_comp_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    (exit_valid && exit_target == EX_COMPLIANCE) |-> !comp_en_ff)
    else $error("compliance path still enabled");
  chk_fb_entry: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fb_ff) |-> $past(rx_cnt) >= NOSIG_RX && $past(sent_cnt) >= FB_SIG_TX && !$past(sig_ff))
    else $error("fallback without its conditions");
  chk_plus_from_two: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff == ST_PLUS && $past(st_ff) == ST_LFPS) |-> $past(sig_cnt) >= SIG_TX)
    else $error("confirmation entered too early");
  chk_sil_after_hs: assert property (@(posedge pclk) disable iff (!presetn)
    (active && sil_exp) |-> hs_ff)
    else $error("silence expiry before handshake");
  chk_portmatch_sig: assert property (@(posedge pclk) disable iff (!presetn)
    (exit_valid && exit_target == EX_PORTMATCH) |-> $past(sig_ff) && $past(sig_cnt) >= SIG_TX)
    else $error("port matching without second signatures");
  cov_base_rxeq: cover property (@(posedge pclk) exit_valid && exit_target == EX_RXEQ);
  cov_portmatch: cover property (@(posedge pclk) exit_valid && exit_target == EX_PORTMATCH);
  cov_fallback: cover property (@(posedge pclk) fb_now);
  cov_timeout: cover property (@(posedge pclk) exit_valid && exit_target == EX_RXDETECT);
  cov_compliance: cover property (@(posedge pclk) exit_valid && exit_target == EX_COMPLIANCE);
endmodule : polling_lfps_exit_control

// ### link_partner_model.sv
`timescale 1ns/10ps
module link_partner_model (
  input wire logic pclk, // Clock
  output logic burst_rcvd, // Pulse per burst
  output logic [1:0] rcvd_sig, // Burst signature
  output logic lfps_present // Line activity
);
  initial begin
    burst_rcvd = 1'b0;
    rcvd_sig = 2'h3;
    lfps_present = 1'b0;
  end
  // Bursts follow one another with no gap burst, so they count as consecutive
  task automatic emit(input int n, input logic [1:0] sig, input logic keep);
    repeat (n) begin
      @(posedge pclk);
      lfps_present <= 1'b1;
      burst_rcvd <= 1'b1;
      rcvd_sig <= sig;
      @(posedge pclk);
      burst_rcvd <= 1'b0;
      // Not qualified between bursts, so never show the old value
      rcvd_sig <= ~sig;
      @(posedge pclk);
    end
    lfps_present <= keep;
  endtask : emit
endmodule : link_partner_model

// ### testbench.sv
`timescale 1ns/10ps
module testbench;
  import lfps_exit_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, burst_sent, warm_reset_seen;
  logic pready, pslverr, burst_rcvd, lfps_present, base_rate, exit_valid, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] rcvd_sig;
  tx_kind_e tx_kind;
  exit_e exit_target;
  int mismatches = 0;
  int checks = 0;

  // Short timers keep the run brief; silence must stay below handshake
  polling_lfps_exit_control #(.HS_CYCLES(200), .SIL_CYCLES(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .burst_sent(burst_sent),
    .burst_rcvd(burst_rcvd), .rcvd_sig(rcvd_sig), .lfps_present(lfps_present),
    .warm_reset_seen(warm_reset_seen), .tx_kind(tx_kind), .base_rate(base_rate),
    .exit_valid(exit_valid), .exit_target(exit_target));
  link_partner_model lp (.pclk(pclk), .burst_rcvd(burst_rcvd), .rcvd_sig(rcvd_sig),
    .lfps_present(lfps_present));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic finish_test();
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(inout int n, input int lim);
    @(posedge pclk);
    n++;
    if (n >= lim) begin
      mismatches++;
      finish_test();
    end
  endtask : tick

  // One idle cycle ahead of each setup, so no signal is driven twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
      tick(n, 50);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic send(input int n);
    repeat (n) begin
      @(posedge pclk);
      burst_sent <= 1'b1;
      @(posedge pclk);
      burst_sent <= 1'b0;
    end
  endtask : send

  task automatic start(input logic [31:0] ctrl);
    apb(1'b1, OFS_CTRL, ctrl);
    apb(1'b1, OFS_CMD, 32'h1 << CMD_START);
  endtask : start

  task automatic wait_exit(input exit_e exp, input string what);
    int n;
    n = 0;
    do
      tick(n, 400);
    while (exit_valid !== 1'b1);
    check(what, 32'(exit_target), 32'(exp));
  endtask : wait_exit

  task automatic wait_state(input logic [1:0] st);
    int n;
    n = 0;
    do begin
      tick(n, 30);
      apb(1'b0, OFS_STAT, 32'h0);
    end while (rd[1:0] !== st);
  endtask : wait_state

  initial begin
    int i;
    presetn = 1'b0;
    {psel, penable, pwrite, burst_sent, warm_reset_seen} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check("tx_kind", 32'(tx_kind), 32'(TX_NONE));
    apb(1'b0, OFS_STAT, 32'h0);
    check("stat", rd & 32'h3373, 32'h100);
    apb(1'b0, OFS_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    start(32'h0);
    wait_exit(EX_COMPLIANCE, "up_compliance");
    start(32'h1);
    // tx_kind is registered one edge after the state, so look one edge later
    repeat (2) @(posedge pclk);
    check("tx_poll", 32'(tx_kind), 32'(TX_POLL));
    send(1);
    lp.emit(2, RX_PLAIN, 1'b1);
    send(14);
    wait_state(2'h1);
    send(1);
    wait_exit(EX_RXEQ, "base_rxeq");
    lp.emit(0, RX_PLAIN, 1'b0);
    apb(1'b0, OFS_STAT, 32'h0);
    check("trained", 32'(rd[9]), 32'h1);
    start(32'h0);
    wait_exit(EX_DISABLED, "periph_to");
    start(32'h2);
    wait_exit(EX_RXDETECT, "hub_to");
    start(32'h0);
    @(posedge pclk);
    warm_reset_seen <= 1'b1;
    @(posedge pclk);
    warm_reset_seen <= 1'b0;
    wait_exit(EX_RXDETECT, "warm_seen");
    // Third timeout in a row must park the port and clear the count
    for (i = 0; i < 3; i++) begin
      start(32'h1);
      wait_exit((i < 2) ? EX_RXDETECT : EX_INACTIVE, "down_to");
      apb(1'b0, OFS_STAT, 32'h0);
      check("to_count", 32'(rd[13:12]), (i < 2) ? (i + 1) : 0);
    end
    start(32'h1);
    apb(1'b1, OFS_CMD, 32'h1 << CMD_DISABLE);
    wait_exit(EX_DISABLED, "dir_disable");
    start(32'h1);
    apb(1'b1, OFS_CMD, 32'h1 << CMD_WARM_RESET);
    wait_exit(EX_RXDETECT, "dir_warm");
    apb(1'b1, OFS_CMD, 32'h1 << CMD_COMPLIANCE_EN);
    start(32'h1);
    wait_exit(EX_COMPLIANCE, "down_compl");
    start(32'h5);
    repeat (2) @(posedge pclk);
    check("tx_sig1", 32'({base_rate, tx_kind}), 32'({1'b0, TX_SIG1}));
    lp.emit(1, RX_SIG1, 1'b1);
    send(2);
    wait_state(2'h2);
    check("tx_sig2", 32'(tx_kind), 32'(TX_SIG2));
    lp.emit(1, RX_SIG2, 1'b1);
    send(2);
    wait_exit(EX_PORTMATCH, "portmatch");
    lp.emit(0, RX_PLAIN, 1'b0);
    // Partner falls silent after its two first-signature bursts, before confirmation is reached
    start(32'h5);
    lp.emit(2, RX_SIG1, 1'b0);
    send(2);
    wait_state(2'h2);
    wait_exit(EX_RXEQ, "silence");
    check("base_sil", 32'(base_rate), 32'h1);
    start(32'h5);
    lp.emit(16, RX_PLAIN, 1'b1);
    send(4);
    repeat (3) @(posedge pclk);
    check("fallback", 32'({base_rate, tx_kind}), 32'({1'b1, TX_POLL}));
    send(15);
    wait_state(2'h1);
    send(1);
    wait_exit(EX_RXEQ, "fb_rxeq");
    lp.emit(0, RX_PLAIN, 1'b0);
    finish_test();
  end
endmodule : testbench
